//--- hw/gim_defs.svh
// timing, pin and bit-position constants for the gyro two-wire master
`ifndef GIM_DEFS_SVH
`define GIM_DEFS_SVH

`define GIM_CLK_NS 10
// quarter of a 100 kHz bus bit
`define GIM_T_QTR_NS 2500
`define GIM_QTR_CYC ((`GIM_T_QTR_NS + `GIM_CLK_NS - 1) / `GIM_CLK_NS)
`define GIM_TMR_W 16
// upper six address bits are a plain default; the strap sets bit 0
`define GIM_ADDR_BASE 7'h58
`define GIM_BUF_DEPTH 2
`define GIM_BIT_ACK 4'h8
`define GIM_PH_SAMPLE 2'h2
`define GIM_PH_LAST 2'h3
`define GIM_DIR_WR 1'h0
`define GIM_DIR_RD 1'h1
`define GIM_ACK 1'h0
`define GIM_NACK 1'h1

`endif

//--- hw/gim_pkg.sv
// types shared by the gyro two-wire master
package gim_pkg;

   typedef enum logic [1:0] {
      GIM_MODE_AUTO = 2'h0,
      GIM_MODE_EVEN = 2'h1,
      GIM_MODE_ODD  = 2'h2
   } gim_mode_type;

   typedef enum logic [2:0] {
      GIM_ST_IDLE  = 3'b000,
      GIM_ST_START = 3'b001,
      GIM_ST_BIT   = 3'b010,
      GIM_ST_WAIT  = 3'b011,
      GIM_ST_STOP  = 3'b100
   } gim_state_type;

   typedef enum logic [2:0] {
      GIM_SP_ADDRW = 3'b000,
      GIM_SP_REG   = 3'b001,
      GIM_SP_WDATA = 3'b010,
      GIM_SP_ADDRR = 3'b011,
      GIM_SP_RDATA = 3'b100
   } gim_step_type;

endpackage

//--- hw/gim_buf.sv
// small shift-style buffer with valid/ready on both sides
`timescale 1ns/10ps
module gim_buf #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 2
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int unsigned CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic [CW-1:0] wpos;
   logic push;
   logic pop;

   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign wpos = pop ? cnt_q - CW'(1) : cnt_q;
   assign out_data_o = mem_q[0];

   always_comb begin
      cnt_d = cnt_q + CW'(push) - CW'(pop);
   end

   // flags come from flops so both sides see clean levels
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= '0;
         out_valid_o <= 1'h0;
         in_ready_o <= 1'h1;
      end else begin
         cnt_q <= cnt_d;
         out_valid_o <= (cnt_d != '0);
         in_ready_o <= (cnt_d != CW'(DEPTH));
      end
   end

   // head always sits in entry 0
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
      end else begin
         for (int i = 0; i < DEPTH; i++) begin
            if (push && CW'(i) == wpos) begin
               mem_q[i] <= in_data_i;
            end else if (pop && i < DEPTH - 1) begin
               mem_q[i] <= mem_q[(i + 1) % DEPTH];
            end
         end
      end
   end

endmodule // gim_buf

//--- hw/gim_master.sv
// two-wire bus master that reads and writes the gyro register port
`timescale 1ns/10ps
`include "gim_defs.svh"

// Functional notes
// - start, bus address, register, then stop/restart
// - address byte: seven bits then direction
// - every byte followed by one ack bit
// - master makes nine clocks per byte
// - transmitter releases data during ack
// - master nacks last byte it reads
// - even mode: extra bit is even parity
// - odd mode: extra bit is odd parity
// - single write: address, register, data, stop
// - burst write repeats data and ack
// - single read via restart, nack, stop
// - burst read: master acks each byte but the last
module gim_master #(
   parameter int unsigned QTR_CYC = `GIM_QTR_CYC,
   parameter logic [6:0] ADDR_BASE = `GIM_ADDR_BASE,
   parameter int unsigned BUF_DEPTH = `GIM_BUF_DEPTH
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // command
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire logic cmd_read_i,
   input wire logic [5:0] cmd_reg_i,
   input wire logic [7:0] cmd_len_i,
   input wire gim_pkg::gim_mode_type cmd_mode_i,
   input wire logic cmd_keep_i,
   // write data
   input wire logic wr_valid_i,
   output logic wr_ready_o,
   input wire logic [7:0] wr_data_i,
   // read data
   output logic rd_valid_o,
   input wire logic rd_ready_i,
   output logic [7:0] rd_data_o,
   // status
   output logic done_o,
   output logic nack_o,
   // pins
   input wire logic address_select_pin_i,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n_o,
   input wire logic serial_data_pin_i,
   output logic serial_data_pin_o,
   output logic serial_data_pin_oe_n_o
);
   import gim_pkg::*;

   localparam logic [`GIM_TMR_W-1:0] TMAX = `GIM_TMR_W'(QTR_CYC - 1);

   function automatic logic [7:0] addr_byte(input logic [6:0] a,
                                            input logic dir);
      addr_byte = {a, dir};
   endfunction

   function automatic logic [7:0] reg_byte(input logic [5:0] r,
                                           input gim_mode_type m,
                                           input logic keep);
      logic x;
      x = keep;
      if (m == GIM_MODE_EVEN) x = ^r;
      else if (m == GIM_MODE_ODD) x = ~^r;
      reg_byte = {1'h0, x, r};
   endfunction

   logic [1:0] rst_sync_q;
   logic rst_n;
   logic [2:0] pin_m_q;
   logic [2:0] pin_s_q;
   logic scl_s;
   logic sda_s;
   logic sel_s;
   gim_state_type state_q;
   gim_step_type step_q;
   gim_mode_type mode_q;
   logic [1:0] ph_q;
   logic [3:0] bit_q;
   logic [`GIM_TMR_W-1:0] tmr_q;
   logic [7:0] sh_q;
   logic [7:0] regb_q;
   logic [7:0] cnt_q;
   logic [6:0] addr_q;
   logic read_q;
   logic ack_q;
   logic err_q;
   logic scl_q;
   logic sda_q;
   logic scl_d;
   logic sda_d;
   logic push_q;
   logic buf_ready;
   logic adv;
   logic rx;

   assign rst_n = rst_sync_q[1];
   assign scl_s = pin_s_q[0];
   assign sda_s = pin_s_q[1];
   assign sel_s = pin_s_q[2];
   assign rx = (step_q == GIM_SP_RDATA);
   // a released clock waits for the line to rise: slave stretching
   assign adv = (tmr_q == TMAX) && (!scl_q || scl_s);
   assign scl_o = scl_q;
   assign scl_oe_n_o = scl_q;
   assign serial_data_pin_o = sda_q;
   assign serial_data_pin_oe_n_o = sda_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) rst_sync_q <= 2'h0;
      else rst_sync_q <= {rst_sync_q[0], 1'h1};
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pin_m_q <= 3'h7;
         pin_s_q <= 3'h7;
      end else begin
         pin_m_q <= {address_select_pin_i, serial_data_pin_i, scl_i};
         pin_s_q <= pin_m_q;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) tmr_q <= '0;
      else if (state_q == GIM_ST_IDLE || state_q == GIM_ST_WAIT || adv)
         tmr_q <= '0;
      else if (tmr_q != TMAX) tmr_q <= tmr_q + `GIM_TMR_W'(1);
   end

   // line levels per phase; scl high only in phases 1 and 2 of a bit
   always_comb begin
      scl_d = 1'h1;
      sda_d = 1'h1;
      case (state_q)
         GIM_ST_START: begin
            scl_d = (ph_q == 2'h0) ? scl_q : (ph_q != `GIM_PH_LAST);
            sda_d = (ph_q < 2'h2);
         end
         GIM_ST_BIT: begin
            scl_d = (ph_q == 2'h1) || (ph_q == `GIM_PH_SAMPLE);
            if (bit_q != `GIM_BIT_ACK) sda_d = rx ? 1'h1 : sh_q[7];
            else if (rx) sda_d = (cnt_q == 8'h1);
            else sda_d = 1'h1;
         end
         GIM_ST_WAIT: scl_d = 1'h0;
         GIM_ST_STOP: begin
            scl_d = (ph_q != 2'h0);
            sda_d = (ph_q >= `GIM_PH_SAMPLE);
         end
         default: ;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         scl_q <= 1'h1;
         sda_q <= 1'h1;
      end else begin
         scl_q <= scl_d;
         sda_q <= sda_d;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= GIM_ST_IDLE;
         step_q <= GIM_SP_ADDRW;
         mode_q <= GIM_MODE_AUTO;
         ph_q <= 2'h0;
         bit_q <= 4'h0;
         sh_q <= 8'h0;
         regb_q <= 8'h0;
         cnt_q <= 8'h0;
         addr_q <= 7'h0;
         read_q <= 1'h0;
         ack_q <= 1'h0;
         err_q <= 1'h0;
         push_q <= 1'h0;
         done_o <= 1'h0;
         cmd_ready_o <= 1'h1;
         wr_ready_o <= 1'h0;
      end else begin
         push_q <= 1'h0;
         done_o <= 1'h0;
         case (state_q)
            GIM_ST_IDLE: begin
               if (cmd_valid_i && cmd_ready_o) begin
                  cmd_ready_o <= 1'h0;
                  read_q <= cmd_read_i;
                  // a read always fetches at least one byte
                  cnt_q <= (cmd_read_i && cmd_len_i == 8'h0) ? 8'h1
                                                            : cmd_len_i;
                  mode_q <= cmd_mode_i;
                  regb_q <= reg_byte(cmd_reg_i, cmd_mode_i,
                                     cmd_keep_i);
                  addr_q <= {ADDR_BASE[6:1], sel_s};
                  sh_q <= addr_byte({ADDR_BASE[6:1], sel_s},
                                    `GIM_DIR_WR);
                  step_q <= GIM_SP_ADDRW;
                  err_q <= 1'h0;
                  ph_q <= 2'h0;
                  state_q <= GIM_ST_START;
               end
            end
            GIM_ST_START: begin
               if (adv) begin
                  ph_q <= ph_q + 2'h1;
                  if (ph_q == `GIM_PH_LAST) begin
                     bit_q <= 4'h0;
                     state_q <= GIM_ST_BIT;
                  end
               end
            end
            GIM_ST_BIT: begin
               if (adv) begin
                  ph_q <= ph_q + 2'h1;
                  if (ph_q == `GIM_PH_SAMPLE) begin
                     if (bit_q == `GIM_BIT_ACK) ack_q <= sda_s;
                     else if (rx) sh_q <= {sh_q[6:0], sda_s};
                  end else if (ph_q == `GIM_PH_LAST) begin
                     bit_q <= bit_q + 4'h1;
                     if (bit_q != `GIM_BIT_ACK && !rx)
                        sh_q <= {sh_q[6:0], 1'h0};
                     if (bit_q == `GIM_BIT_ACK) begin
                        bit_q <= 4'h0;
                        if (!rx && ack_q == `GIM_NACK) begin
                           err_q <= 1'h1;
                           state_q <= GIM_ST_STOP;
                        end else begin
                           case (step_q)
                              GIM_SP_ADDRW: begin
                                 sh_q <= regb_q;
                                 step_q <= GIM_SP_REG;
                              end
                              GIM_SP_REG: begin
                                 if (read_q) begin
                                    sh_q <= addr_byte(addr_q, `GIM_DIR_RD);
                                    step_q <= GIM_SP_ADDRR;
                                    state_q <= GIM_ST_START;
                                 end else if (cnt_q == 8'h0) begin
                                    state_q <= GIM_ST_STOP;
                                 end else begin
                                    step_q <= GIM_SP_WDATA;
                                    state_q <= GIM_ST_WAIT;
                                    wr_ready_o <= 1'h1;
                                 end
                              end
                              GIM_SP_WDATA: begin
                                 cnt_q <= cnt_q - 8'h1;
                                 if (cnt_q == 8'h1) begin
                                    state_q <= GIM_ST_STOP;
                                 end else begin
                                    state_q <= GIM_ST_WAIT;
                                    wr_ready_o <= 1'h1;
                                 end
                              end
                              GIM_SP_ADDRR: begin
                                 step_q <= GIM_SP_RDATA;
                                 state_q <= GIM_ST_WAIT;
                              end
                              default: begin
                                 cnt_q <= cnt_q - 8'h1;
                                 push_q <= 1'h1;
                                 state_q <= (cnt_q == 8'h1) ? GIM_ST_STOP
                                                            : GIM_ST_WAIT;
                              end
                           endcase
                        end
                     end
                  end
               end
            end
            GIM_ST_WAIT: begin
               // clock is held low until data or buffer room exists
               ph_q <= 2'h0;
               if (step_q == GIM_SP_WDATA) begin
                  if (wr_valid_i) begin
                     sh_q <= wr_data_i;
                     wr_ready_o <= 1'h0;
                     state_q <= GIM_ST_BIT;
                  end
               end else if (buf_ready && !push_q) begin
                  state_q <= GIM_ST_BIT;
               end
            end
            GIM_ST_STOP: begin
               if (adv) begin
                  ph_q <= ph_q + 2'h1;
                  if (ph_q == `GIM_PH_LAST) begin
                     done_o <= 1'h1;
                     cmd_ready_o <= 1'h1;
                     state_q <= GIM_ST_IDLE;
                  end
               end
            end
            default: state_q <= GIM_ST_IDLE;
         endcase
      end
   end

   assign nack_o = err_q;

   gim_buf #(
      .WIDTH(8),
      .DEPTH(BUF_DEPTH)
   ) u_rd_buf (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .in_valid_i(push_q),
      .in_ready_o(buf_ready),
      .in_data_i(sh_q),
      .out_valid_o(rd_valid_o),
      .out_ready_i(rd_ready_i),
      .out_data_o(rd_data_o)
   );

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n);

   a_cmd_start: assert property (
      cmd_valid_i && cmd_ready_o |=> state_q == GIM_ST_START)
      else $error("command not followed by start");
   a_start_edge: assert property (
      $fell(sda_q) && scl_q |-> state_q == GIM_ST_START)
      else $error("data fell under high clock outside start");
   a_addr_dir: assert property (
      state_q == GIM_ST_BIT && bit_q == 4'h0 && ph_q == 2'h0 &&
      (step_q == GIM_SP_ADDRW || step_q == GIM_SP_ADDRR)
      |-> sh_q[0] == (step_q == GIM_SP_ADDRR) && sh_q[7:1] == addr_q)
      else $error("address byte wrong");
   a_data_low_clk: assert property (
      $changed(sda_q) && state_q == GIM_ST_BIT |-> !scl_q)
      else $error("data changed while clock high");
   a_ack_release: assert property (
      state_q == GIM_ST_BIT && bit_q == `GIM_BIT_ACK && !rx &&
      ph_q != 2'h0 |-> sda_q)
      else $error("data not released in ack slot");
   a_read_last_nack: assert property (
      state_q == GIM_ST_BIT && bit_q == `GIM_BIT_ACK && rx &&
      cnt_q == 8'h1 && ph_q != 2'h0 |-> sda_q)
      else $error("last read byte not nacked");
   a_read_burst_ack: assert property (
      state_q == GIM_ST_BIT && bit_q == `GIM_BIT_ACK && rx &&
      cnt_q > 8'h1 && ph_q != 2'h0 |-> !sda_q)
      else $error("burst read byte not acked");
   a_nack_abort: assert property (
      state_q == GIM_ST_BIT && bit_q == `GIM_BIT_ACK && !rx && adv &&
      ph_q == `GIM_PH_LAST && ack_q
      |=> state_q == GIM_ST_STOP && err_q ##1 nack_o)
      else $error("slave nack did not abort");
   a_even_parity: assert property (
      state_q == GIM_ST_BIT && step_q == GIM_SP_REG && bit_q == 4'h0 &&
      ph_q == 2'h0 && mode_q == GIM_MODE_EVEN |-> sh_q[6] == ^sh_q[5:0])
      else $error("even parity bit wrong");
   a_odd_parity: assert property (
      state_q == GIM_ST_BIT && step_q == GIM_SP_REG && bit_q == 4'h0 &&
      ph_q == 2'h0 && mode_q == GIM_MODE_ODD |-> sh_q[6] == ~^sh_q[5:0])
      else $error("odd parity bit wrong");

endmodule // gim_master

//--- verif/gim_dev_model.sv
// behavioural register-port device seen from the two-wire bus
`timescale 1ns/10ps
module gim_dev_model #(
   parameter logic [6:0] ADDR_BASE = 7'h58,
   parameter logic [5:0] REG_LAST = 6'h2F,
   parameter int STRETCH_NS = 300
) (
   // bus levels and the master's data release
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic m_rel_i,
   // straps and behaviour
   input wire logic strap_i,
   input wire logic busy_i,
   input wire logic slow_i,
   input wire gim_pkg::gim_mode_type mode_i,
   // pull-downs and status
   output logic sda_low_o,
   output logic scl_low_o,
   output logic perr_o,
   output int merr_o
);
   import gim_pkg::*;
   logic [7:0] mem [64];
   logic [7:0] sh;
   logic [5:0] ptr;
   logic keep;
   logic hit;
   int st;
   int bc;
   initial begin
      for (int i = 0; i < 64; i++) begin
         mem[i] = 8'(i * 7 + 3);
      end
      {sda_low_o, scl_low_o, perr_o, keep, hit, ptr, sh} = '0;
      merr_o = 0;
      st = 0;
      bc = 0;
   end
   // st: 0 idle, 1 address, 2 register, 3 write, 4 read, 5 ignore, 6 read go
   always @(negedge sda_i) begin
      if (scl_i) begin
         st = 1;
         bc = 0;
      end
   end
   always @(posedge sda_i) begin
      if (scl_i) begin
         st = 0;
      end
   end
   always @(posedge scl_i) begin
      if (sda_low_o && !m_rel_i) merr_o++;
      if (bc < 8) sh = {sh[6:0], sda_i};
      else if (st == 4 && sda_i) st = 5;
      else if (st == 4 && !keep) ptr++;
      bc++;
   end
   always @(negedge scl_i) begin
      if (bc == 8 && st == 1) begin
         hit = sh[7:1] == {ADDR_BASE[6:1], strap_i};
         sda_low_o = hit && !busy_i;
         st = !sda_low_o ? 5 : (sh[0] ? 6 : 2);
      end else if (bc == 8 && st == 2) begin
         ptr = sh[5:0];
         keep = mode_i == GIM_MODE_AUTO && sh[6];
         perr_o = mode_i != GIM_MODE_AUTO &&
            sh[6] != (^sh[5:0] ^ (mode_i == GIM_MODE_ODD));
         sda_low_o = sh[5:0] <= REG_LAST && !busy_i;
         st = sda_low_o ? 3 : 5;
      end else if (bc == 8 && st == 3) begin
         sda_low_o = !busy_i;
         if (!busy_i) mem[ptr] = sh;
         if (!keep) ptr++;
      end else if (bc == 8) begin
         sda_low_o = 0;
      end else if (bc == 9) begin
         bc = 0;
         sda_low_o = 0;
         if (st == 6) st = 4;
      end
      if (st == 4 && bc < 8) sda_low_o = !mem[ptr][7 - bc];
   end
   // slow answer: hold the clock low a while after each falling edge
   always @(negedge scl_i) begin
      if (slow_i) begin
         scl_low_o = 1;
         #(STRETCH_NS);
         scl_low_o = 0;
      end
   end
endmodule // gim_dev_model

//--- verif/gyro_i2c_register_port_tb_top.sv
// self-checking bench: two-wire master against a behavioural device
`timescale 1ns/10ps
module gyro_i2c_register_port_tb_top;
   import gim_pkg::*;
   logic clk, rst_n, cmd_valid, cmd_ready, cmd_read, cmd_keep;
   logic wr_valid, wr_ready, rd_valid, rd_ready, done, nack;
   logic m_strap, d_strap, busy, slow, stall, perr;
   logic scl_oe_n, sda_oe_n, d_sda_low, d_scl_low, scl_out, sda_out;
   logic [5:0] cmd_reg;
   logic [7:0] cmd_len, wr_data, rd_data;
   gim_mode_type cmd_mode;
   logic [7:0] exp_mem [64];
   logic [7:0] wq [$];
   logic [7:0] got [$];
   logic [5:0] rl [3] = '{6'h00, 6'h23, 6'h2F};
   int bad_count, checks, pulls, merr;
   // released lines float to the pull-up level
   wire scl_w = scl_oe_n & !d_scl_low;
   wire sda_w = sda_oe_n & !d_sda_low;

   gim_master #(.QTR_CYC(4)) dut (
      .clk_i(clk), .rst_n_i(rst_n),
      .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
      .cmd_read_i(cmd_read), .cmd_reg_i(cmd_reg), .cmd_len_i(cmd_len),
      .cmd_mode_i(cmd_mode), .cmd_keep_i(cmd_keep),
      .wr_valid_i(wr_valid), .wr_ready_o(wr_ready), .wr_data_i(wr_data),
      .rd_valid_o(rd_valid), .rd_ready_i(rd_ready), .rd_data_o(rd_data),
      .done_o(done), .nack_o(nack), .address_select_pin_i(m_strap),
      .scl_i(scl_w), .scl_o(scl_out), .scl_oe_n_o(scl_oe_n),
      .serial_data_pin_i(sda_w), .serial_data_pin_o(sda_out),
      .serial_data_pin_oe_n_o(sda_oe_n)
   );

   gim_dev_model dev (
      .scl_i(scl_w), .sda_i(sda_w), .m_rel_i(sda_oe_n), .strap_i(d_strap),
      .busy_i(busy), .slow_i(slow), .mode_i(cmd_mode), .sda_low_o(d_sda_low),
      .scl_low_o(d_scl_low), .perr_o(perr), .merr_o(merr)
   );

   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   always @(posedge d_sda_low) pulls++;

   // write bytes leave on each handshake; read bytes land in got
   always @(posedge clk) begin
      if (wr_valid && wr_ready) void'(wq.pop_front());
      wr_valid <= wq.size() > 0;
      wr_data <= wq.size() > 0 ? wq[0] : 8'h00;
      if (rd_valid && rd_ready) got.push_back(rd_data);
      rd_ready <= !stall && $urandom_range(1, 0) == 1;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // one command; ok says whether every byte should be acknowledged
   task automatic xfer(input bit rd, input logic [5:0] rg, input int len,
         input gim_mode_type md, input bit kp, input bit ok);
      int n;
      int t;
      logic [7:0] b;
      logic [5:0] p;
      n = (rd && len == 0) ? 1 : len;
      p = rg;
      t = 0;
      got.delete();
      for (int i = 0; i < n && !rd; i++) begin
         b = 8'($urandom);
         wq.push_back(b);
         if (ok) exp_mem[p] = b;
         if (!(md == GIM_MODE_AUTO && kp)) p++;
      end
      @(posedge clk);
      cmd_valid <= 1;
      cmd_read <= rd;
      cmd_reg <= rg;
      cmd_len <= 8'(len);
      cmd_mode <= md;
      cmd_keep <= kp;
      @(posedge clk);
      check({7'h0, cmd_ready}, 8'h01);
      cmd_valid <= 0;
      // a refused read hands over no byte, so only done ends the wait
      while ((!done || got.size() < n && rd && ok) && t < 30000) begin
         @(posedge clk);
         t++;
      end
      if (t == 30000) begin
         bad_count++;
         final_report();
      end
      wq.delete();
      check({7'h0, nack}, {7'h0, !ok});
      check({6'h0, scl_out, sda_out}, 8'h03);
      if (rd) check(8'(got.size()), ok ? 8'(n) : 8'h00);
      for (int i = 0; i < n && rd && ok; i++) begin
         check(got[i], exp_mem[rg]);
         if (!(md == GIM_MODE_AUTO && kp)) rg++;
      end
   endtask

   initial begin
      int t;
      void'($urandom(71));
      {cmd_valid, cmd_read, cmd_keep, wr_valid, rd_ready} = '0;
      {m_strap, d_strap, busy, slow, stall, rst_n} = '0;
      cmd_reg = 6'h00;
      cmd_len = 8'h00;
      wr_data = 8'h00;
      cmd_mode = GIM_MODE_AUTO;
      for (int i = 0; i < 64; i++) exp_mem[i] = 8'(i * 7 + 3);
      repeat (16) @(posedge clk);
      rst_n <= 1;
      for (int s = 0; s < 2; s++) begin
         m_strap <= s[0];
         d_strap <= s[0];
         repeat (4) @(posedge clk);
         xfer(0, 6'h05, 1, GIM_MODE_AUTO, 0, 1);
         xfer(1, 6'h05, 0, GIM_MODE_AUTO, 0, 1);
      end
      xfer(0, 6'h0A, 3, GIM_MODE_AUTO, 0, 1);
      stall <= 1;
      fork
         xfer(1, 6'h09, 4, GIM_MODE_AUTO, 0, 1);
         begin
            repeat (1500) @(posedge clk);
            check({7'h0, rd_valid}, 8'h01);
            stall <= 0;
         end
      join
      xfer(0, 6'h14, 2, GIM_MODE_AUTO, 1, 1);
      xfer(1, 6'h14, 2, GIM_MODE_AUTO, 1, 1);
      for (int m = 1; m < 3; m++) begin
         for (int r = 0; r < 3; r++) begin
            xfer(0, rl[r], 1, gim_mode_type'(m), 0, 1);
            check({7'h0, perr}, 8'h00);
            xfer(1, rl[r], 2, gim_mode_type'(m), 0, 1);
         end
      end
      xfer(0, 6'h3E, 1, GIM_MODE_AUTO, 0, 0);
      xfer(0, 6'h30, 0, GIM_MODE_AUTO, 0, 0);
      busy <= 1;
      xfer(0, 6'h05, 1, GIM_MODE_AUTO, 0, 0);
      busy <= 0;
      m_strap <= 0;
      repeat (4) @(posedge clk);
      t = pulls;
      xfer(1, 6'h05, 1, GIM_MODE_AUTO, 0, 0);
      check(8'(pulls - t), 8'h00);
      m_strap <= 1;
      slow <= 1;
      repeat (4) @(posedge clk);
      xfer(0, 6'h0B, 1, GIM_MODE_AUTO, 0, 1);
      xfer(1, 6'h0A, 3, GIM_MODE_AUTO, 0, 1);
      slow <= 0;
      check(8'(merr), 8'h00);
      final_report();
   end
endmodule // gyro_i2c_register_port_tb_top
